// ---- hw/bbp_pkg.sv ----
// Shared constants and carrier types for the four-channel pin-toggling port.
package bbp_pkg;

	localparam int unsigned BBP_CHANNELS = 4;
	localparam int unsigned BBP_WIDTH    = 8;

	// Mode-setting command values.
	localparam logic [7:0] BBP_CMD_RESET = 8'h00;
	localparam logic [7:0] BBP_CMD_ASYNC = 8'h01;
	localparam logic [7:0] BBP_CMD_SYNC  = 8'h04;

	// Setup time after a synchronous update, in clock cycles.
	localparam int unsigned BBP_SETUP_CYCLES = 1;

	localparam logic [7:0] BBP_PINS_RESET = 8'h00;

	typedef enum logic [1:0] {
		BBP_MODE_UART,
		BBP_MODE_ASYNC,
		BBP_MODE_SYNC
	} bbp_mode_t;

	// Mode command from the host side: value and per-pin direction mask.
	typedef struct packed {
		logic       valid;
		logic [1:0] chan;
		logic [7:0] value;
		logic [7:0] dir_mask;
	} bbp_mode_cmd_t;

	// Data byte from the host side for one channel.
	typedef struct packed {
		logic       valid;
		logic [1:0] chan;
		logic [7:0] data;
	} bbp_data_cmd_t;

	// Sampled byte returned to the host side.
	typedef struct packed {
		logic       valid;
		logic [1:0] chan;
		logic [7:0] data;
	} bbp_sample_t;

endpackage : bbp_pkg

// ---- hw/bbp_mode_dec.sv ----
// Decoder from a mode command value to a channel mode.
`timescale 1ns/1ps
`default_nettype none
module bbp_mode_dec (
	input  wire logic [7:0]         value,
	input  wire bbp_pkg::bbp_mode_t current,
	output logic                    known,
	output bbp_pkg::bbp_mode_t      mode
);
	import bbp_pkg::*;

	wire is_reset = (value == BBP_CMD_RESET);
	wire is_async = (value == BBP_CMD_ASYNC);
	wire is_sync  = (value == BBP_CMD_SYNC);

	// Unknown values (other engines not built here) keep the current mode.
	assign known = is_reset | is_async | is_sync;
	assign mode  = is_async ? BBP_MODE_ASYNC :
	               is_sync  ? BBP_MODE_SYNC  :
	               is_reset ? BBP_MODE_UART  : current;

endmodule : bbp_mode_dec
`default_nettype wire

// ---- hw/bbp_channel.sv ----
// One channel of the pin-toggling port: mode, pin driver and sampler.
`timescale 1ns/1ps
`default_nettype none
module bbp_channel #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             mode_wr,
	input  wire logic [7:0]       mode_val,
	input  wire logic [WIDTH-1:0] mode_mask,
	input  wire logic             data_wr,
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0]      pins_out,
	output logic [WIDTH-1:0]      pins_oe_n,
	output logic                  smp_valid,
	output logic [WIDTH-1:0]      smp_data,
	output logic                  busy,
	output bbp_pkg::bbp_mode_t    mode
);
	import bbp_pkg::*;

	initial begin
		if (WIDTH != BBP_WIDTH) $error("bbp_channel: WIDTH must be 8");
	end

	bbp_mode_t        mode_ff;
	logic [WIDTH-1:0] out_ff;
	logic [WIDTH-1:0] mask_ff;
	logic [WIDTH-1:0] oe_n_ff;
	logic             smp_v_ff;
	logic [WIDTH-1:0] smp_ff;
	logic             setup_ff;
	logic             dec_known;
	bbp_mode_t        dec_mode;

	bbp_mode_dec u_dec (
		.value   (mode_val),
		.current (mode_ff),
		.known   (dec_known),
		.mode    (dec_mode)
	);

	wire       pin_mode  = (mode_ff != BBP_MODE_UART);
	wire       sync_wr   = data_wr && (mode_ff == BBP_MODE_SYNC) && !setup_ff;
	wire       async_wr  = data_wr && (mode_ff == BBP_MODE_ASYNC);
	wire       mode_take = mode_wr && dec_known;
	wire [WIDTH-1:0] nxt_oe_n = (dec_mode == BBP_MODE_UART) ?
	                            {WIDTH{1'b1}} : ~mode_mask;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= BBP_MODE_UART;
			mask_ff <= BBP_PINS_RESET;
			oe_n_ff <= ~BBP_PINS_RESET;
		end else if (mode_take) begin
			mode_ff <= dec_mode;
			mask_ff <= mode_mask;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// Sample is taken from the pins before the new byte lands; the
	// setup cycle follows, during which a further write is refused.
	// sample, drive, setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_ff   <= BBP_PINS_RESET;
			smp_v_ff <= 1'b0;
			smp_ff   <= BBP_PINS_RESET;
			setup_ff <= 1'b0;
		end else begin
			smp_v_ff <= sync_wr;
			setup_ff <= sync_wr;
			if (sync_wr) begin
				smp_ff <= pins_in;
			end
			if (sync_wr || async_wr) begin
				out_ff <= data;
			end
		end
	end

	assign pins_out  = out_ff;
	assign pins_oe_n = oe_n_ff;
	assign smp_valid = smp_v_ff;
	assign smp_data  = smp_ff;
	assign busy      = setup_ff;
	assign mode      = mode_ff;

	sample_only_sync_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		smp_v_ff |-> $past(data_wr) && $past(mode_ff) == BBP_MODE_SYNC)
		else $error("sample returned without a synchronous write");
	sample_old_pins_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		smp_v_ff |-> smp_ff == $past(pins_in))
		else $error("sample not taken before the update");
	async_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(mode_ff == BBP_MODE_ASYNC && !data_wr) |=> $stable(out_ff))
		else $error("asynchronous output changed without a byte");
	sync_setup_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		sync_wr |=> setup_ff ##1 !setup_ff)
		else $error("setup cycle not exactly one cycle");
	uart_release_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(mode_take && mode_val == BBP_CMD_RESET) |=> oe_n_ff == '1)
		else $error("return to default left pins driven");
	mask_drive_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		pin_mode |-> oe_n_ff == ~mask_ff)
		else $error("driven pins differ from direction mask");

endmodule : bbp_channel
`default_nettype wire

// ---- hw/bbp_port.sv ----
// Four-channel parallel pin-toggling port with per-channel mode selection.
//
// Contract
// - Every channel can enter pin-toggling mode, synchronous or asynchronous.
// - Asynchronous mode holds the last host byte on the pins.
// - Synchronous mode changes pins only when a byte is delivered.
// - Synchronous mode returns exactly one pin sample per byte accepted; a byte refused during setup returns none.
// - Mode command value 1 selects asynchronous pin-toggling.
// - Mode command value 4 selects synchronous pin-toggling.
// - Synchronous write samples pins first, then drives the new data.
// - One clock of data setup follows each synchronous output update.
// - No read or write strobe pins are driven in pin-toggling modes.
// - After reset all channels are serial UART, no pin-toggling active.
// - Stored configuration only picks the driver enable in UART mode.
// - Each channel keeps its own mode; others stay unaffected.
// - Mode command value 0 returns a channel to default behaviour.
`timescale 1ns/1ps
`default_nettype none
module bbp_port #(
	parameter int unsigned CHANNELS = 4,
	parameter int unsigned WIDTH    = 8
) (
	input  wire logic                         MCLK,
	input  wire logic                         RST_N,
	input  wire bbp_pkg::bbp_mode_cmd_t       MODE_CMD,
	input  wire bbp_pkg::bbp_data_cmd_t       DATA_CMD,
	input  wire logic [CHANNELS-1:0]          CFG_DRIVER_ENABLE,
	input  wire logic [CHANNELS-1:0]          UART_TX_ACTIVE,
	input  wire logic [CHANNELS*WIDTH-1:0]    PINS_IN,
	output logic [CHANNELS*WIDTH-1:0]         PINS_OUT,
	output logic [CHANNELS*WIDTH-1:0]         PINS_OE_N,
	output bbp_pkg::bbp_sample_t              SAMPLE,
	output logic [CHANNELS-1:0]               DATA_BUSY,
	output logic [CHANNELS-1:0]               PIN_MODE_ACTIVE,
	output logic [CHANNELS-1:0]               TRANSMIT_DRIVER_ENABLE
);
	import bbp_pkg::*;

	initial begin
		if (CHANNELS != BBP_CHANNELS) $error("bbp_port: CHANNELS must be 4");
		if (WIDTH != BBP_WIDTH) $error("bbp_port: WIDTH must be 8");
	end

	function automatic logic hit(input logic v, input logic [1:0] c,
	                             input int unsigned i);
		hit = v && (c == i[1:0]);
	endfunction : hit

	logic [CHANNELS*WIDTH-1:0] ch_out;
	logic [CHANNELS*WIDTH-1:0] ch_oe_n;
	logic [CHANNELS*WIDTH-1:0] ch_smp;
	logic [CHANNELS-1:0]       ch_smp_v;
	logic [CHANNELS-1:0]       ch_busy;
	logic [CHANNELS-1:0]       ch_active;
	logic [CHANNELS-1:0]       nxt_transmit_driver_enable;
	logic [CHANNELS-1:0]       transmit_driver_enable_ff;
	logic [CHANNELS-1:0]       busy_ff;
	logic [CHANNELS-1:0]       active_ff;
	logic [CHANNELS*WIDTH-1:0] out_ff;
	logic [CHANNELS*WIDTH-1:0] oe_n_ff;
	bbp_sample_t               nxt_sample;
	bbp_sample_t               sample_ff;

	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		bbp_mode_t  mode;
		wire        mode_wr = hit(MODE_CMD.valid, MODE_CMD.chan, i);
		wire        data_wr = hit(DATA_CMD.valid, DATA_CMD.chan, i);

		bbp_channel #(
			.WIDTH (WIDTH)
		) u_ch (
			.clk       (MCLK),
			.rst_n     (RST_N),
			.mode_wr   (mode_wr),
			.mode_val  (MODE_CMD.value),
			.mode_mask (MODE_CMD.dir_mask),
			.data_wr   (data_wr),
			.data      (DATA_CMD.data),
			.pins_in   (PINS_IN[i*WIDTH +: WIDTH]),
			.pins_out  (ch_out[i*WIDTH +: WIDTH]),
			.pins_oe_n (ch_oe_n[i*WIDTH +: WIDTH]),
			.smp_valid (ch_smp_v[i]),
			.smp_data  (ch_smp[i*WIDTH +: WIDTH]),
			.busy      (ch_busy[i]),
			.mode      (mode)
		);

		assign ch_active[i] = (mode != BBP_MODE_UART);
		assign nxt_transmit_driver_enable[i] = (mode == BBP_MODE_UART) &&
		                      CFG_DRIVER_ENABLE[i] && UART_TX_ACTIVE[i];
	end

	// One data byte per cycle reaches one channel, so at most one sample
	// is valid at a time; the lowest index wins only as a safety net.
	always_comb begin
		nxt_sample = '0;
		for (int unsigned i = 0; i < CHANNELS; i++) begin
			if (ch_smp_v[i] && !nxt_sample.valid) begin
				nxt_sample.valid = 1'b1;
				nxt_sample.chan  = i[1:0];
				nxt_sample.data  = ch_smp[i*WIDTH +: WIDTH];
			end
		end
	end

	// Outputs are re-registered so every port comes straight from a flop;
	// the cost is one extra cycle of latency on pins and samples.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			out_ff    <= '0;
			oe_n_ff   <= '1;
			sample_ff <= '0;
			busy_ff   <= '0;
			active_ff <= '0;
			transmit_driver_enable_ff  <= '0;
		end else begin
			out_ff    <= ch_out;
			oe_n_ff   <= ch_oe_n;
			sample_ff <= nxt_sample;
			busy_ff   <= ch_busy;
			active_ff <= ch_active;
			transmit_driver_enable_ff  <= nxt_transmit_driver_enable;
		end
	end

	assign PINS_OUT               = out_ff;
	assign PINS_OE_N              = oe_n_ff;
	assign SAMPLE                 = sample_ff;
	assign DATA_BUSY              = busy_ff;
	assign PIN_MODE_ACTIVE        = active_ff;
	assign TRANSMIT_DRIVER_ENABLE = transmit_driver_enable_ff;

	reset_uart_a: assert property (
		@(posedge MCLK)
		$rose(RST_N) |-> active_ff == '0 && oe_n_ff == '1)
		else $error("channel not in UART mode after reset");
	async_select_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		(MODE_CMD.valid && MODE_CMD.value == BBP_CMD_ASYNC) ##1 1 ##1 1
		|-> active_ff[$past(MODE_CMD.chan, 2)])
		else $error("value 1 did not enter asynchronous mode");
	sync_select_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		(MODE_CMD.valid && MODE_CMD.value == BBP_CMD_SYNC) ##2 1
		|-> active_ff[$past(MODE_CMD.chan, 2)])
		else $error("value 4 did not enter synchronous mode");
	default_return_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		(MODE_CMD.valid && MODE_CMD.value == BBP_CMD_RESET) ##2 1
		|-> !active_ff[$past(MODE_CMD.chan, 2)])
		else $error("value 0 did not return to default");
	transmit_driver_enable_gate_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		(transmit_driver_enable_ff & active_ff) == '0)
		else $error("driver enable raised outside UART mode");
	sample_pair_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		sample_ff.valid |-> $past(DATA_CMD.valid, 2) &&
		$past(DATA_CMD.chan, 2) == sample_ff.chan)
		else $error("sample without matching byte written");

endmodule : bbp_port
`default_nettype wire

// ---- tb/bbp_pin_model.sv ----
// Model of the external logic that shares the parallel pins.
`timescale 1ns/1ps
`default_nettype none
module bbp_pin_model (
	input  wire logic [31:0] pins_out,
	input  wire logic [31:0] pins_oe_n,
	input  wire logic [31:0] ext_drive,
	output logic [31:0]      pins_in
);
	// released pins read
	// A released pin shows the outside level, never a stale copy of port data.
	assign pins_in = (pins_out & ~pins_oe_n) | (ext_drive & pins_oe_n);
endmodule : bbp_pin_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the four-channel pin-toggling port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bbp_pkg::*;
	logic          MCLK = 1'b0;
	logic          RST_N = 1'b0;
	bbp_mode_cmd_t mode_cmd = '0;
	bbp_data_cmd_t data_cmd = '0;
	logic [3:0]    cfg_de = 4'h0;
	logic [3:0]    tx_act = 4'h0;
	logic [31:0]   ext_drive = 32'h5A5A5A5A;
	logic [31:0]   pins_in, pins_out, pins_oe_n;
	bbp_sample_t   sample;
	bbp_sample_t   last_smp = '0;
	logic [3:0]    busy, active, tde;
	int            err_count = 0, n_checks = 0, cycles = 0, n_samples = 0;

	bbp_port i_bbp_port (.MCLK(MCLK), .RST_N(RST_N), .MODE_CMD(mode_cmd),
		.DATA_CMD(data_cmd), .CFG_DRIVER_ENABLE(cfg_de),
		.UART_TX_ACTIVE(tx_act), .PINS_IN(pins_in), .PINS_OUT(pins_out),
		.PINS_OE_N(pins_oe_n), .SAMPLE(sample), .DATA_BUSY(busy),
		.PIN_MODE_ACTIVE(active), .TRANSMIT_DRIVER_ENABLE(tde));
	bbp_pin_model i_bbp_pin_model (.pins_out(pins_out),
		.pins_oe_n(pins_oe_n), .ext_drive(ext_drive), .pins_in(pins_in));

	always #50 MCLK = ~MCLK;

	// Each sample pulse lasts one cycle, so it is counted once per edge.
	always @(posedge MCLK) begin
		cycles++;
		// The pulse is gone before the tasks return, so the last one is kept.
		if (sample.valid === 1'b1) begin
			n_samples++;
			last_smp = sample;
		end
		if (cycles > 3000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// Both tasks start and end on a falling edge; results have landed by then.
	task automatic set_mode(input logic [1:0] ch, input logic [7:0] v, m);
		mode_cmd <= '{1'b1, ch, v, m};
		@(negedge MCLK);
		mode_cmd <= '0;
		repeat (2) @(negedge MCLK);
	endtask : set_mode

	task automatic put(input logic [1:0] ch, input logic [7:0] d);
		data_cmd <= '{1'b1, ch, d};
		@(negedge MCLK);
		data_cmd <= '0;
		repeat (2) @(negedge MCLK);
	endtask : put

	initial begin
		repeat (4) @(negedge MCLK);
		check("reset oe", pins_oe_n, 32'hFFFFFFFF);
		check("reset mode", active, 4'h0);
		check("reset out", pins_out, 32'h0);
		RST_N <= 1'b1;
		@(negedge MCLK);
		set_mode(2'h1, BBP_CMD_ASYNC, 8'hFF);
		check("async mode", active, 4'h2);
		check("async oe", pins_oe_n, 32'hFFFF00FF);
		data_cmd <= '{1'b1, 2'h1, 8'h11};
		@(negedge MCLK);
		data_cmd <= '{1'b1, 2'h1, 8'h22};
		@(negedge MCLK);
		data_cmd <= '0;
		repeat (6) @(negedge MCLK);
		check("async hold", pins_out[15:8], 8'h22);
		check("async no sample", n_samples, 0);
		set_mode(2'h0, BBP_CMD_SYNC, 8'h0F);
		check("sync oe", pins_oe_n[7:0], 8'hF0);
		check("sync mode", active, 4'h3);
		put(2'h0, 8'hA5);
		check("first sample", last_smp.data, 8'h50);
		check("sync out", pins_out[7:0], 8'hA5);
		// The second byte lands in the setup cycle and must be dropped.
		data_cmd <= '{1'b1, 2'h0, 8'h3C};
		@(negedge MCLK);
		data_cmd <= '{1'b1, 2'h0, 8'h0F};
		@(negedge MCLK);
		// The busy level stands for one cycle only, so it is read here.
		check("setup busy", busy, 4'h1);
		data_cmd <= '0;
		@(negedge MCLK);
		check("sample before drive", last_smp.data, 8'h55);
		ext_drive <= 32'hA5A5A5A5;
		repeat (5) @(negedge MCLK);
		check("refused byte", pins_out[7:0], 8'h3C);
		check("one sample per byte", n_samples, 2);
		set_mode(2'h1, 8'h02, 8'h00);
		check("unknown value", active, 4'h3);
		set_mode(2'h0, BBP_CMD_RESET, 8'h00);
		check("back to default", active, 4'h2);
		check("released pins", pins_oe_n[7:0], 8'hFF);
		put(2'h0, 8'h77);
		check("uart ignores byte", pins_out[7:0], 8'h3C);
		cfg_de <= 4'hF;
		tx_act <= 4'hF;
		repeat (3) @(negedge MCLK);
		check("driver enable", tde, 4'hD);
		RST_N <= 1'b0;
		@(negedge MCLK);
		check("second reset", active, 4'h0);
		check("second reset tde", tde, 4'h0);
		RST_N <= 1'b1;
		@(negedge MCLK);
		// The host reissues each channel's mode after the reset.
		for (int c = 0; c < 4; c++) begin
			set_mode(c[1:0], BBP_CMD_ASYNC, 8'h81);
			check("channel mode", active[c], 1'b1);
		end
		check("mask per pin", pins_oe_n, 32'h7E7E7E7E);
		// A sample from a channel other than zero carries its own index.
		set_mode(2'h2, BBP_CMD_SYNC, 8'h0F);
		put(2'h2, 8'h96);
		check("sample channel", last_smp.chan, 2'h2);
		check("sample data", last_smp.data, 8'hA0);
		check("sync out ch2", pins_out[23:16], 8'h96);
		check("others kept", active, 4'hF);
		check("sample count", n_samples, 3);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
